/* core/level_interrupt_controller.sv */
// eight-level interrupt controller with mask, group priorities and the
// acknowledge, stack-push and vector-fetch sequence; assumes peripherals
// and cpu core run on clk_sys_i and rom data returns in the same cycle as the read strobe
//
// Function
// R1 - reset clears global enable and fast enable bits
// R2 - fast level select field is left unreset
// R3 - enable instruction sets global enable, disable instruction clears it
// R4 - software must enable interrupts after reset before any servicing
// R5 - mask bit n at zero blocks level n, one passes it
// R6 - mask register unreset; software must initialise all bits
// R7 - priority register unreset; software must program it before use
// R8 - highest priority level first; lower vector address wins in a level
// R9 - groups: A levels 0-1, B levels 2-4, C levels 5-7
// R10 - priority bits 7,4,1 order groups; 001 B>C>A, 101 C>B>A
// R11 - priority bit 5 orders group C, bit 6 orders levels 6 and 7
// R12 - priority bit 0 orders level 0 against level 1
// R13 - request status is read only, bit n shows level n request
// R14 - reset clears request status
// R15 - status records requests while disabled; servicing waits for enable
// R16 - hardware cleared source sets hidden pending bit, cleared on acknowledge
// R17 - level zero timer overflow uses hardware cleared pending bit
// R18 - software cleared sources get cleared by the service routine
// R19 - service needs global enable, unmasked, top priority, source enabled
// R20 - acknowledge at instruction end, clear enable, save state, vector
// R21 - push pc low, pc high, flags; fetch vector high, low; jump
// R22 - vector entries sit at even addresses in rom bytes 00 to ff
// R23 - interrupt return sets global enable again
// R24 - fast select field picks level, fast enable turns it on
// R25 - acknowledge clears only the chosen level's hardware pending bit
`timescale 1ns/1ns
`include "intc_map.svh"

module level_interrupt_controller
    import intc_pkg::*;
#(
    parameter logic [7:0] HW_CLEAR_LEVELS = `HW_CLEAR_LEVELS,
    parameter logic [63:0] VEC_TABLE = 64'hf8f0_e8e0_d8d0_c8c0
)
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // register port
    input wire reg_port_s reg_i,
    output logic [7:0] reg_rdata_o,
    // peripheral sources
    input wire logic [7:0] sw_level_req_i,
    input wire logic [7:0] hw_src_event_i,
    // cpu state and control
    input wire cpu_ctl_s cpu_i,
    input wire logic [15:0] pc_i,
    input wire logic [7:0] flags_i,
    input wire logic [7:0] rom_data_i,
    // cpu request and acknowledge
    output logic cpu_irq_o,
    output logic interrupt_acknowledge_o,
    output logic [2:0] ack_level_o,
    output logic fast_swap_o,
    // stack and vector
    output logic stack_push_o,
    output logic [7:0] push_data_o,
    output logic rom_rd_o,
    output logic [7:0] rom_addr_o,
    output logic jump_o,
    output logic [15:0] jump_addr_o
);

    // ======================================================
    // declarations
    logic global_en_reg;
    logic fast_en_reg;
    logic [2:0] fast_sel_reg;
    logic [7:0] level_mask_reg;
    logic [7:0] prio_reg;
    logic [7:0] hw_pend_reg;
    logic [7:0] req_status;
    logic [7:0] qualified;
    logic win_valid;
    logic [2:0] win_level;
    logic win_hw;
    logic take;
    logic take_fast;
    logic interrupt_return_instr_seen;
    logic [7:0] vec_addr;
    logic [7:0] vec_addr_reg;
    logic [7:0] vec_hi_reg;
    seq_state_e state_reg;
    logic wr_sym;
    logic wr_mask;
    logic wr_prio;

    // ======================================================
    // register decode
    assign wr_sym = reg_i.wr && (reg_i.addr == `SYS_MODE_OFS);
    assign wr_mask = reg_i.wr && (reg_i.addr == `LEVEL_MASK_OFS);
    assign wr_prio = reg_i.wr && (reg_i.addr == `LEVEL_PRIO_OFS);

    // ======================================================
    // hidden pending bits for hardware cleared sources
    genvar n;
    generate
        for (n = 0; n < 8; n++)
        begin : g_pend
            always_ff @(posedge clk_sys_i)
            begin
                // a new event wins over a clear in the same cycle
                if (reset_i)
                    hw_pend_reg[n] <= 1'b0; // see R14
                else if (HW_CLEAR_LEVELS[n] && hw_src_event_i[n]) // see R16
                    hw_pend_reg[n] <= 1'b1; // see R17
                else if (take && win_hw && (win_level == 3'(n)))
                    hw_pend_reg[n] <= 1'b0; // see R25
            end
        end
    endgenerate

    // ======================================================
    // request status and qualification
    assign req_status = sw_level_req_i | hw_pend_reg; // see R15
    assign qualified = req_status & level_mask_reg; // see R5

    level_priority_arbiter u_arb (
        .req_i(qualified),
        .prio_i(prio_reg),
        .valid_o(win_valid),
        .level_o(win_level)
    );

    // ======================================================
    // winner, take and vector
    // lower vector address of a level belongs to its hardware cleared source
    assign win_hw = hw_pend_reg[win_level]; // see R8
    assign take = global_en_reg && win_valid && cpu_i.instr_end
                  && (state_reg == SEQ_IDLE); // see R19
    assign take_fast = fast_en_reg && (fast_sel_reg == win_level); // see R24
    assign vec_addr = (VEC_TABLE[8 * win_level +: 8] & 8'hfe)
                      + (win_hw ? 8'h00 : `SW_VEC_STEP); // see R22
    assign interrupt_return_instr_seen = cpu_i.interrupt_return_instr;

    // ======================================================
    // system mode control
    // take clears, then return, enable, disable, register write
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            global_en_reg <= 1'b0; // see R1
            fast_en_reg <= 1'b0; // see R1
        end
        else
        begin
            if (take)
                global_en_reg <= 1'b0; // see R20
            else if (interrupt_return_instr_seen)
                global_en_reg <= 1'b1; // see R23
            else if (cpu_i.enable_interrupts_instr)
                global_en_reg <= 1'b1; // see R3
            else if (cpu_i.disable_interrupts_instr)
                global_en_reg <= 1'b0; // see R3
            else if (wr_sym)
                global_en_reg <= reg_i.wdata[`SYM_GLOBAL_EN_BIT];
            if (wr_sym)
                fast_en_reg <= reg_i.wdata[`SYM_FAST_EN_BIT];
        end
    end

    // ======================================================
    // fast select, mask and priority hold no reset value
    always_ff @(posedge clk_sys_i)
    begin
        if (wr_sym) // see R2
            fast_sel_reg <= reg_i.wdata[`SYM_FAST_SEL_MSB:`SYM_FAST_SEL_LSB];
        if (wr_mask) // see R6
            level_mask_reg <= reg_i.wdata;
        if (wr_prio) // see R7
            prio_reg <= reg_i.wdata;
    end

    // ======================================================
    // register read
    // unmapped addresses read as zero
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            reg_rdata_o <= `RDATA_RST;
        else if (reg_i.rd)
        begin
            if (reg_i.addr == `REQ_STATUS_OFS)
                reg_rdata_o <= req_status; // see R13
            else if (reg_i.addr == `LEVEL_MASK_OFS)
                reg_rdata_o <= level_mask_reg;
            else if (reg_i.addr == `SYS_MODE_OFS)
                reg_rdata_o <= {3'b000, fast_sel_reg, fast_en_reg,
                                global_en_reg};
            else if (reg_i.addr == `LEVEL_PRIO_OFS)
                reg_rdata_o <= prio_reg;
            else
                reg_rdata_o <= `RDATA_RST;
        end
    end

    // ======================================================
    // request line to the cpu
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            cpu_irq_o <= 1'b0; // see R14
        else
            cpu_irq_o <= global_en_reg && win_valid; // see R15
    end

    // ======================================================
    // acknowledge and vectoring sequence
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            state_reg <= SEQ_IDLE;
            interrupt_acknowledge_o <= 1'b0;
            ack_level_o <= 3'd0;
            fast_swap_o <= 1'b0;
            stack_push_o <= 1'b0;
            push_data_o <= 8'h00;
            rom_rd_o <= 1'b0;
            rom_addr_o <= 8'h00;
            jump_o <= 1'b0;
            jump_addr_o <= 16'h0000;
            vec_addr_reg <= 8'h00;
            vec_hi_reg <= 8'h00;
        end
        else
        begin
            interrupt_acknowledge_o <= 1'b0;
            fast_swap_o <= 1'b0;
            stack_push_o <= 1'b0;
            rom_rd_o <= 1'b0;
            jump_o <= 1'b0;
            // strobes fall back low unless a step raises them
            case (state_reg)
                SEQ_IDLE:
                begin
                    if (take) // see R20
                    begin
                        interrupt_acknowledge_o <= 1'b1;
                        ack_level_o <= win_level;
                        vec_addr_reg <= vec_addr;
                        if (take_fast)
                            fast_swap_o <= 1'b1; // see R24
                        else
                        begin
                            state_reg <= SEQ_PUSH_PCL;
                            stack_push_o <= 1'b1; // see R21
                            push_data_o <= pc_i[7:0];
                        end
                    end
                end
                SEQ_PUSH_PCL:
                begin
                    state_reg <= SEQ_PUSH_PCH;
                    stack_push_o <= 1'b1; // see R21
                    push_data_o <= pc_i[15:8];
                end
                SEQ_PUSH_PCH:
                begin
                    state_reg <= SEQ_PUSH_FLG;
                    stack_push_o <= 1'b1; // see R21
                    push_data_o <= flags_i;
                end
                SEQ_PUSH_FLG:
                begin
                    state_reg <= SEQ_FETCH_HI;
                    rom_rd_o <= 1'b1; // see R21
                    rom_addr_o <= vec_addr_reg;
                end
                SEQ_FETCH_HI:
                begin
                    state_reg <= SEQ_FETCH_LO;
                    rom_rd_o <= 1'b1;
                    rom_addr_o <= vec_addr_reg | 8'h01;
                    vec_hi_reg <= rom_data_i;
                end
                SEQ_FETCH_LO:
                begin
                    state_reg <= SEQ_JUMP;
                    jump_o <= 1'b1; // see R21
                    jump_addr_o <= {vec_hi_reg, rom_data_i};
                end
                SEQ_JUMP:
                begin
                    state_reg <= SEQ_IDLE;
                end
                default:
                begin
                    state_reg <= SEQ_IDLE;
                end
            endcase
        end
    end

endmodule : level_interrupt_controller

/* core/intc_map.svh */
// register offsets, field positions and reset values of the interrupt
// controller; assumes an 8-bit register file address space
`ifndef INTC_MAP_SVH
`define INTC_MAP_SVH

// ==========================================================
// register offsets
`define REQ_STATUS_OFS 8'hdc
`define LEVEL_MASK_OFS 8'hdd
`define SYS_MODE_OFS 8'hde
`define LEVEL_PRIO_OFS 8'hff

// ==========================================================
// system mode control fields
`define SYM_GLOBAL_EN_BIT 0
`define SYM_FAST_EN_BIT 1
`define SYM_FAST_SEL_LSB 2
`define SYM_FAST_SEL_MSB 4

// ==========================================================
// priority config fields
`define PRIO_A_BIT 0
`define PRIO_GRP_LO_BIT 1
`define PRIO_GRP_MID_BIT 4
`define PRIO_C_BIT 5
`define PRIO_SUBC_BIT 6
`define PRIO_GRP_HI_BIT 7

// ==========================================================
// reset values and misc
`define REQ_STATUS_RST 8'h00
`define RDATA_RST 8'h00
`define SW_VEC_STEP 8'h02
`define HW_CLEAR_LEVELS 8'h01

`endif

/* core/intc_pkg.sv */
// types shared by the interrupt controller files
// assumes intc_map.svh for the numeric constants
package intc_pkg;

    // ======================================================
    // interrupt cycle sequence
    typedef enum logic [6:0] {
        SEQ_IDLE = 7'b000_0001,
        SEQ_PUSH_PCL = 7'b000_0010,
        SEQ_PUSH_PCH = 7'b000_0100,
        SEQ_PUSH_FLG = 7'b000_1000,
        SEQ_FETCH_HI = 7'b001_0000,
        SEQ_FETCH_LO = 7'b010_0000,
        SEQ_JUMP = 7'b100_0000
    } seq_state_e;

    // ======================================================
    // register port carrier
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_port_s;

    // ======================================================
    // cpu control carrier
    typedef struct packed {
        logic instr_end;
        logic enable_interrupts_instr;
        logic disable_interrupts_instr;
        logic interrupt_return_instr;
    } cpu_ctl_s;

endpackage : intc_pkg

/* core/level_priority_arbiter.sv */
// combinational level arbiter: picks the winning level among requests
// assumes requests are already masked; the global enable is applied after the arbiter
`timescale 1ns/1ns
`include "intc_map.svh"

module level_priority_arbiter
    import intc_pkg::*;
(
    // requests and priority config
    input wire logic [7:0] req_i,
    input wire logic [7:0] prio_i,
    // winner
    output logic valid_o,
    output logic [2:0] level_o
);

    logic [2:0] win_a;
    logic [2:0] win_b;
    logic [2:0] win_c;
    logic [2:0] win_67;
    logic [2:0] grp_code;
    logic [1:0] order [3];
    logic [2:0] grp_has;
    logic [2:0] grp_win [3];

    // ======================================================
    // winners inside each group
    always_comb
    begin
        if (prio_i[`PRIO_A_BIT]) // see R12
            win_a = req_i[1] ? 3'd1 : 3'd0;
        else
            win_a = req_i[0] ? 3'd0 : 3'd1;
        if (req_i[2])
            win_b = 3'd2;
        else if (req_i[3])
            win_b = 3'd3;
        else
            win_b = 3'd4;
        if (prio_i[`PRIO_SUBC_BIT]) // see R11
            win_67 = req_i[7] ? 3'd7 : 3'd6;
        else
            win_67 = req_i[6] ? 3'd6 : 3'd7;
        if (prio_i[`PRIO_C_BIT]) // see R11
            win_c = (req_i[6] | req_i[7]) ? win_67 : 3'd5;
        else
            win_c = req_i[5] ? 3'd5 : win_67;
    end

    // ======================================================
    // group order, 0 = A, 1 = B, 2 = C
    assign grp_code = {prio_i[`PRIO_GRP_HI_BIT], prio_i[`PRIO_GRP_MID_BIT],
                       prio_i[`PRIO_GRP_LO_BIT]};
    assign grp_has = {|req_i[7:5], |req_i[4:2], |req_i[1:0]}; // see R9
    assign grp_win[0] = win_a;
    assign grp_win[1] = win_b;
    assign grp_win[2] = win_c;

    always_comb
    begin
        case (grp_code) // see R10
            3'b001: order = '{2'd1, 2'd2, 2'd0};
            3'b010: order = '{2'd0, 2'd1, 2'd2};
            3'b011: order = '{2'd1, 2'd0, 2'd2};
            3'b100: order = '{2'd2, 2'd0, 2'd1};
            3'b101: order = '{2'd2, 2'd1, 2'd0};
            3'b110: order = '{2'd0, 2'd2, 2'd1};
            default: order = '{2'd0, 2'd1, 2'd2};
        endcase
    end

    always_comb
    begin
        valid_o = |req_i;
        if (grp_has[order[0]]) // see R8
            level_o = grp_win[order[0]];
        else if (grp_has[order[1]])
            level_o = grp_win[order[1]];
        else
            level_o = grp_win[order[2]];
    end

endmodule : level_priority_arbiter

/* bench/lic_properties.sv */
// port timing checker for the interrupt controller
// assumes it is bound onto level_interrupt_controller
`timescale 1ns/1ns

module lic_properties
    import intc_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // watched ports
    input wire reg_port_s reg_i,
    input wire logic [7:0] reg_rdata_o,
    input wire cpu_ctl_s cpu_i,
    input wire logic cpu_irq_o,
    input wire logic interrupt_acknowledge_o,
    input wire logic [2:0] ack_level_o,
    input wire logic fast_swap_o,
    input wire logic stack_push_o,
    input wire logic rom_rd_o,
    input wire logic [7:0] rom_addr_o,
    input wire logic jump_o
);
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (reset_i);

    // ==========
    // properties
    property p_reset_quiet;
        $fell(reset_i) |-> !cpu_irq_o && !interrupt_acknowledge_o && !jump_o;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs active after reset");
    property p_take_at_end;
        interrupt_acknowledge_o |-> $past(cpu_i.instr_end);
    endproperty
    a_take_at_end: assert property (p_take_at_end)
        else $error("acknowledge without instruction end");
    property p_seq;
        interrupt_acknowledge_o && !fast_swap_o |-> stack_push_o ##1
            stack_push_o ##1 stack_push_o ##1 rom_rd_o && !stack_push_o
            ##1 rom_rd_o ##1 jump_o;
    endproperty
    a_seq: assert property (p_seq)
        else $error("vector sequence out of order");
    property p_busy;
        interrupt_acknowledge_o && !fast_swap_o |=>
            !interrupt_acknowledge_o [*6];
    endproperty
    a_busy: assert property (p_busy)
        else $error("new take during sequence");
    property p_lo_fetch;
        rom_rd_o && $past(rom_rd_o) |->
            rom_addr_o == ($past(rom_addr_o) | 8'h01);
    endproperty
    a_lo_fetch: assert property (p_lo_fetch)
        else $error("low byte fetch address wrong");
    property p_hi_even;
        rom_rd_o && !$past(rom_rd_o) |-> !rom_addr_o[0];
    endproperty
    a_hi_even: assert property (p_hi_even)
        else $error("vector address odd");
    property p_ge_cleared;
        interrupt_acknowledge_o && !cpu_i.enable_interrupts_instr &&
            !cpu_i.interrupt_return_instr && !reg_i.wr |=> !cpu_irq_o;
    endproperty
    a_ge_cleared: assert property (p_ge_cleared)
        else $error("request stays up after take");
    property p_fast_alone;
        fast_swap_o |-> interrupt_acknowledge_o ##1 !stack_push_o && !rom_rd_o;
    endproperty
    a_fast_alone: assert property (p_fast_alone)
        else $error("fast take pushes");
    property p_level_hold;
        !interrupt_acknowledge_o |-> $stable(ack_level_o);
    endproperty
    a_level_hold: assert property (p_level_hold)
        else $error("acknowledged level moved");
    property p_unmapped;
        reg_i.rd && !(reg_i.addr inside {8'hdc, 8'hdd, 8'hde, 8'hff})
            |=> reg_rdata_o == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
endmodule : lic_properties

bind level_interrupt_controller lic_properties u_props (.clk_sys_i, .reset_i,
    .reg_i, .reg_rdata_o, .cpu_i, .cpu_irq_o, .interrupt_acknowledge_o,
    .ack_level_o, .fast_swap_o, .stack_push_o, .rom_rd_o, .rom_addr_o,
    .jump_o);

/* bench/src_rom_model.sv */
// model of software-cleared sources and of the program rom
// assumes the bench raises and clears sources at clock edges
`timescale 1ns/1ns

module src_rom_model
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // source control
    input wire logic [7:0] raise_i,
    input wire logic [7:0] clear_i,
    output logic [7:0] level_req_o,
    // rom port
    input wire logic rom_rd_i,
    input wire logic [7:0] rom_addr_i,
    output logic [7:0] rom_data_o
);
    // request holds until the routine writes zero
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            level_req_o <= 8'h00;
        else
            level_req_o <= (level_req_o | raise_i) & ~clear_i;
    end

    // byte answered within the read cycle, toggling garbage otherwise
    logic [7:0] junk_reg;

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            junk_reg <= 8'h00;
        else
            junk_reg <= ~junk_reg;
    end

    assign rom_data_o = rom_rd_i ? (rom_addr_i ^ 8'h5a) : junk_reg;
endmodule : src_rom_model

/* bench/level_interrupt_controller_tb.sv */
// self-checking bench of the interrupt controller
// assumes src_rom_model as source and rom partner
`timescale 1ns/1ns

module level_interrupt_controller_tb
    import intc_pkg::*;
;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    reg_port_s reg_i = '0;
    cpu_ctl_s cpu_i = 4'h8;
    logic [7:0] hw_src_event_i = 8'h00;
    logic [7:0] raise = 8'h00;
    logic [7:0] clear = 8'h00;
    logic [7:0] sw_level_req_i, rom_data_i, reg_rdata_o;
    logic [7:0] push_data_o, rom_addr_o;
    logic cpu_irq_o, interrupt_acknowledge_o, fast_swap_o;
    logic stack_push_o, rom_rd_o, jump_o;
    logic [2:0] ack_level_o;
    logic [15:0] jump_addr_o;
    int num_errors = 0;
    int samples_checked = 0;
    logic [18:0] tab [11] = '{{8'h00, 8'h03, 3'h0}, {8'h01, 8'h03, 3'h1},
        {8'h02, 8'h25, 3'h2}, {8'h82, 8'h25, 3'h5}, {8'h10, 8'h25, 3'h0},
        {8'h12, 8'h25, 3'h2}, {8'h80, 8'h25, 3'h5}, {8'h90, 8'h24, 3'h5},
        {8'h92, 8'h25, 3'h0}, {8'ha2, 8'he0, 3'h6}, {8'he2, 8'he0, 3'h7}};

    level_interrupt_controller uut (.clk_sys_i, .reset_i, .reg_i,
        .reg_rdata_o, .sw_level_req_i, .hw_src_event_i, .cpu_i,
        .pc_i(16'h1234), .flags_i(8'ha9), .rom_data_i, .cpu_irq_o,
        .interrupt_acknowledge_o, .ack_level_o, .fast_swap_o, .stack_push_o,
        .push_data_o, .rom_rd_o, .rom_addr_o, .jump_o, .jump_addr_o);

    src_rom_model model (.clk_sys_i, .reset_i, .raise_i(raise),
        .clear_i(clear), .level_req_o(sw_level_req_i), .rom_rd_i(rom_rd_o),
        .rom_addr_i(rom_addr_o), .rom_data_o(rom_data_i));

    initial
    begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    // ==========
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick();
        @(posedge clk_sys_i);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_i <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_sys_i);
        reg_i.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] m,
                      input logic [7:0] e);
        @(posedge clk_sys_i);
        reg_i <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_sys_i);
        reg_i.rd <= 1'b0;
        #1;
        chk(reg_rdata_o & m, e);
    endtask : rd

    task automatic ctl(input cpu_ctl_s c);
        @(posedge clk_sys_i);
        cpu_i <= c;
        @(posedge clk_sys_i);
        cpu_i <= 4'h8;
    endtask : ctl

    task automatic src(input logic [7:0] r, input logic [7:0] c,
                       input logic [7:0] h);
        @(posedge clk_sys_i);
        raise <= r;
        clear <= c;
        hw_src_event_i <= h;
        @(posedge clk_sys_i);
        raise <= 8'h00;
        clear <= 8'h00;
        hw_src_event_i <= 8'h00;
    endtask : src

    task automatic wait_ack();
        int n;
        n = 0;
        #1;
        while (interrupt_acknowledge_o !== 1'b1 && n < 50)
        begin
            tick();
            n++;
        end
        chk(interrupt_acknowledge_o, 1'b1);
    endtask : wait_ack

    task automatic take(input logic [2:0] lv, input logic [7:0] va);
        wait_ack();
        chk(ack_level_o, lv);
        chk(cpu_irq_o, 1'b1);
        chk({stack_push_o, push_data_o}, {1'b1, 8'h34});
        tick();
        chk({stack_push_o, push_data_o}, {1'b1, 8'h12});
        tick();
        chk({stack_push_o, push_data_o}, {1'b1, 8'ha9});
        tick();
        chk({rom_rd_o, rom_addr_o}, {1'b1, va});
        tick();
        chk({rom_rd_o, rom_addr_o}, {1'b1, va | 8'h01});
        tick();
        chk({jump_o, jump_addr_o}, {1'b1, va ^ 8'h5a, va ^ 8'h5b});
    endtask : take

    // ==========
    // scenarios
    task automatic t_reset();
        rd(8'hdc, 8'hff, 8'h00);
        rd(8'hde, 8'h03, 8'h00);
        wr(8'hdc, 8'hff);
        rd(8'hdc, 8'hff, 8'h00);
        rd(8'h10, 8'hff, 8'h00);
    endtask : t_reset

    task automatic t_disabled();
        wr(8'hdd, 8'hff);
        wr(8'hff, 8'h00);
        src(8'ha5, 8'h00, 8'h00);
        rd(8'hdc, 8'hff, 8'ha5);
        chk(cpu_irq_o, 1'b0);
        ctl(4'hc);
        take(3'h0, 8'hc2);
        src(8'h00, 8'hff, 8'h00);
        ctl(4'h9);
        rd(8'hde, 8'h01, 8'h01);
        ctl(4'ha);
        rd(8'hde, 8'h01, 8'h00);
    endtask : t_disabled

    task automatic t_mask();
        wr(8'hdd, 8'h00);
        src(8'h08, 8'h00, 8'h00);
        ctl(4'hc);
        rd(8'hde, 8'h01, 8'h01);
        chk(cpu_irq_o, 1'b0);
        wr(8'hdd, 8'h08);
        take(3'h3, 8'hda);
        src(8'h00, 8'hff, 8'h00);
    endtask : t_mask

    task automatic t_priority();
        wr(8'hdd, 8'hff);
        for (int i = 0; i < 11; i++)
        begin
            wr(8'hff, tab[i][18:11]);
            src(tab[i][10:3], 8'h00, 8'h00);
            ctl(4'hc);
            take(tab[i][2:0],
                8'hc2 + {2'b00, tab[i][2:0], 3'b000});
            src(8'h00, 8'hff, 8'h00);
        end
    endtask : t_priority

    task automatic t_pending();
        wr(8'hff, 8'h00);
        src(8'h09, 8'h00, 8'h03);
        rd(8'hdc, 8'hff, 8'h09);
        ctl(4'hc);
        take(3'h0, 8'hc0);
        ctl(4'h9);
        take(3'h0, 8'hc2);
        src(8'h00, 8'h01, 8'h00);
        rd(8'hdc, 8'hff, 8'h08);
        ctl(4'h9);
        take(3'h3, 8'hda);
        src(8'h00, 8'hff, 8'h00);
    endtask : t_pending

    task automatic t_fast();
        wr(8'hde, 8'h0e);
        rd(8'hde, 8'h1f, 8'h0e);
        src(8'h08, 8'h00, 8'h00);
        ctl(4'hc);
        wait_ack();
        chk(fast_swap_o, 1'b1);
        tick();
        chk(stack_push_o, 1'b0);
        src(8'h00, 8'hff, 8'h00);
        wr(8'hde, 8'h00);
    endtask : t_fast

    task automatic final_report();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    initial
    begin
        repeat (20) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        t_reset();
        t_disabled();
        t_mask();
        t_priority();
        t_pending();
        t_fast();
        final_report();
    end

    initial
    begin
        #100000;
        num_errors++;
        final_report();
    end
endmodule : level_interrupt_controller_tb
